/* File: wit_pkg.sv */
// Constants shared by both ends of the watchdog / interval timer link
package wit_pkg;
	// ****************************************
	// Device bus encodings
	// ****************************************
	localparam logic [1:0] WIT_SZ_BYTE = 2'h0;
	localparam logic [1:0] WIT_SZ_WORD = 2'h1;
	localparam logic [1:0] WIT_SZ_LONG = 2'h2;
	// Offsets from the block base: csr/counter share a write word
	localparam logic [1:0] WIT_OFF_CSR = 2'h0; // Control/status read, shared write
	localparam logic [1:0] WIT_OFF_CNT = 2'h1; // Counter read
	localparam logic [1:0] WIT_OFF_RST_WR = 2'h2; // Reset control write
	localparam logic [1:0] WIT_OFF_RST_RD = 2'h3; // Reset control read
	localparam logic [31:0] WIT_ADDR_CSR = 32'h05FFFFB8;
	localparam logic [31:0] WIT_ADDR_CNT = 32'h05FFFFB9;
	localparam logic [31:0] WIT_ADDR_RST_WR = 32'h05FFFFBA;
	localparam logic [31:0] WIT_ADDR_RST_RD = 32'h05FFFFBB;
	// Upper byte keys of word writes
	localparam logic [7:0] WIT_KEY_CNT = 8'h5A;
	localparam logic [7:0] WIT_KEY_CSR = 8'hA5;
	localparam logic [7:0] WIT_KEY_RST_BITS = 8'h5A;
	localparam logic [7:0] WIT_KEY_RST_CLR = 8'hA5;
	localparam logic [7:0] WIT_RST_CLR_DATA = 8'h00;
	// ****************************************
	// Register fields and reset values
	// ****************************************
	localparam int WIT_B_FLAG = 7; // Overflow flag in both registers
	localparam int WIT_B_MODE = 6; // Mode select / reset enable
	localparam int WIT_B_TME = 5; // Count enable / reset type
	localparam logic [7:0] WIT_CSR_RESET = 8'h18;
	localparam logic [7:0] WIT_CSR_ONES = 8'h18; // Reserved bits read one
	localparam logic [7:0] WIT_RST_RESET = 8'h1F;
	localparam logic [7:0] WIT_CNT_RESET = 8'h00;
	localparam logic [7:0] WIT_CNT_MAX = 8'hFF;
	// ****************************************
	// Timing counts in system clocks
	// ****************************************
	localparam int WIT_PRE_W = 13;
	localparam logic [7:0] WIT_OVF_OUT_CYC = 8'd128;
	localparam logic [9:0] WIT_IRST_CYC = 10'd512;
	// ****************************************
	// APB map of the host controller
	// ****************************************
	localparam logic [7:0] WIT_APB_CMD = 8'h00;
	localparam logic [7:0] WIT_APB_STAT = 8'h04;
	localparam int WIT_CMD_WR = 18; // 1 word write, 0 byte read
	localparam int WIT_CMD_OFF = 16; // Offset field [17:16]
endpackage : wit_pkg

/* File: wit_bus_if.sv */
// Internal peripheral bus joining the host controller and the timer
`timescale 1ns/10ps
`default_nettype none
interface wit_bus_if;
	logic req; // One-cycle request
	logic wr; // 1 write, 0 read
	logic [1:0] size; // Transfer size
	logic [1:0] offset; // Register offset
	logic [15:0] wdata; // Write word
	logic [7:0] rdata; // Read byte
	logic ack; // One-cycle answer
	modport dev (input req, wr, size, offset, wdata, output rdata, ack);
	modport host (output req, wr, size, offset, wdata, input rdata, ack);
endinterface : wit_bus_if
`default_nettype wire

/* File: wit_host.sv */
// Host end: APB slave that issues timer bus transfers
`timescale 1ns/10ps
`default_nettype none
module wit_host import wit_pkg::*; (
	input wire logic sys_clk_in, // 25 MHz clock
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	wit_bus_if.host bus // Timer bus
);
	typedef enum logic [1:0] {
		WIT_H_IDLE = 2'b01,
		WIT_H_WAIT = 2'b10
	} wit_hst_e;

	wit_hst_e st_r, st_nxt;
	logic req_r, req_nxt, wr_r, wr_nxt;
	logic [1:0] size_r, size_nxt, off_r, off_nxt;
	logic [15:0] wd_r, wd_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt, setup;

	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.size = size_r;
	assign bus.offset = off_r;
	assign bus.wdata = wd_r;

	// ****************************************
	// APB decode and transfer sequencing
	// ****************************************
	always_comb begin
		setup = psel && !penable;
		st_nxt = st_r;
		req_nxt = 1'b0;
		wr_nxt = wr_r;
		size_nxt = size_r;
		off_nxt = off_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h00000000;
		case (st_r)
			WIT_H_IDLE: begin
			end
			WIT_H_WAIT: begin
				if (bus.ack) begin
					st_nxt = WIT_H_IDLE;
					if (!wr_r) begin
						rd_nxt = bus.rdata;
					end
				end
			end
			default: st_nxt = WIT_H_IDLE;
		endcase
		if (setup) begin
			if (paddr == WIT_APB_CMD) begin
				if (pwrite && st_r == WIT_H_IDLE) begin
					st_nxt = WIT_H_WAIT;
					req_nxt = 1'b1;
					wr_nxt = pwdata[WIT_CMD_WR];
					off_nxt = pwdata[WIT_CMD_OFF +: 2];
					wd_nxt = pwdata[15:0];
					// Writes go as words, reads as bytes
					size_nxt = pwdata[WIT_CMD_WR] ? WIT_SZ_WORD : WIT_SZ_BYTE;
					// Reserved control bits always written as ones
					if (pwdata[WIT_CMD_WR] && pwdata[WIT_CMD_OFF +: 2] == WIT_OFF_CSR &&
						pwdata[15:8] == WIT_KEY_CSR) begin
						wd_nxt = pwdata[15:0] | {8'h00, WIT_CSR_ONES};
					end
				end
				prdata_nxt = {13'h0000, wr_r, off_r, wd_r};
			end else if (paddr == WIT_APB_STAT) begin
				prdata_nxt = {16'h0000, rd_r, 7'h00, (st_r == WIT_H_WAIT)};
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	// Register the sequencer and APB answer
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_r <= WIT_H_IDLE;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			size_r <= WIT_SZ_BYTE;
			off_r <= 2'h0;
			wd_r <= 16'h0000;
			rd_r <= 8'h00;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			wr_r <= wr_nxt;
			size_r <= size_nxt;
			off_r <= off_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end
endmodule : wit_host
`default_nettype wire

/* File: wit_device.sv */
// Device end: watchdog / interval timer with counter and two control registers
// Operation
// - 8-bit counter counts selected divided clock pulses
// - Wrap from FF raises overflow output or interrupt
// - Counter cleared by reset, disable; kept in standby, where a counter write clears it
// - Control bits 7-5 clear in standby, 2-0 kept
// - Reserved control bits read one, written one
// - Interval flag set only in interval mode
// - Interval flag cleared by read-one then write-zero
// - Mode bit picks interval timer or watchdog
// - Disabled counter held at zero outside standby
// - Clock select codes pick eight divide ratios
// - Watchdog flag set only in watchdog mode
// - Watchdog flag cleared by read-one then write-zero
// - Watchdog overflow resets chip if enabled
// - Reset type bit picks power-on or manual
// - Reset register initialised by pin reset, standby
// - Registers written only by word transfers
// - Registers read only by byte transfers
// - Key byte routes shared write to counter/control
// - Reset register key writes clear flag, set bits
// - Overflow output 128 cycles, reset 512 cycles
// - Counter write beats a coinciding count pulse
`timescale 1ns/10ps
`default_nettype none
module wit_device import wit_pkg::*; (
	input wire logic sys_clk_in, // 25 MHz clock
	input wire logic rst_n_in, // Reset pin, synchronous, active low
	input wire logic standby_in, // Standby mode entry/hold
	output logic overflow_out_n_out, // External overflow, active low
	output logic interval_interrupt_out, // Interval interrupt request
	output logic por_reset_out, // Internal power-on reset request
	output logic manual_reset_out, // Internal manual reset request
	wit_bus_if.dev bus // Register bus
);
	// ****************************************
	// State
	// ****************************************
	logic [WIT_PRE_W-1:0] pre_r, pre_nxt;
	logic [7:0] watchdog_counter_r, watchdog_counter_nxt;
	logic interval_overflow_flag_r, interval_overflow_flag_nxt;
	logic mode_select_r, mode_select_nxt;
	logic count_enable_bit_r, count_enable_bit_nxt;
	logic [2:0] clock_divider_select_r, clock_divider_select_nxt;
	logic watchdog_overflow_flag_r, watchdog_overflow_flag_nxt;
	logic internal_reset_enable_r, internal_reset_enable_nxt;
	logic reset_type_select_r, reset_type_select_nxt;
	logic ovf_armed_r, ovf_armed_nxt, watchdog_overflow_flag_armed_r, watchdog_overflow_flag_armed_nxt;
	logic [7:0] ovfo_cnt_r, ovfo_cnt_nxt;
	logic [9:0] irst_cnt_r, irst_cnt_nxt;
	logic irst_type_r, irst_type_nxt;
	logic ack_nxt;
	logic [7:0] rdata_nxt, ctrl_status_reg, reset_ctrl_reg;
	logic tick, wrap, wd_wrap, it_wrap;
	logic wr_word, rd_byte, wr_cnt, wr_csr, wr_rst_clr, wr_rst_bits;

	// Low-bit mask of the prescaler for each clock select code
	function automatic logic [WIT_PRE_W-1:0] wit_div_mask(input logic [2:0] sel);
		case (sel)
			3'h0: wit_div_mask = 13'h0001;
			3'h1: wit_div_mask = 13'h003F;
			3'h2: wit_div_mask = 13'h007F;
			3'h3: wit_div_mask = 13'h00FF;
			3'h4: wit_div_mask = 13'h01FF;
			3'h5: wit_div_mask = 13'h03FF;
			3'h6: wit_div_mask = 13'h0FFF;
			default: wit_div_mask = 13'h1FFF;
		endcase
	endfunction : wit_div_mask

	// Register images as read back
	assign ctrl_status_reg = {interval_overflow_flag_r, mode_select_r, count_enable_bit_r,
		2'b11, clock_divider_select_r};
	assign reset_ctrl_reg = {watchdog_overflow_flag_r, internal_reset_enable_r,
		reset_type_select_r, 5'h1F};

	// ****************************************
	// Bus decode
	// ****************************************
	always_comb begin
		wr_word = bus.req && bus.wr && bus.size == WIT_SZ_WORD;
		rd_byte = bus.req && !bus.wr && bus.size == WIT_SZ_BYTE;
		wr_cnt = 1'b0;
		wr_csr = 1'b0;
		wr_rst_clr = 1'b0;
		wr_rst_bits = 1'b0;
		if (wr_word && bus.offset == WIT_OFF_CSR) begin
			wr_cnt = bus.wdata[15:8] == WIT_KEY_CNT;
			wr_csr = bus.wdata[15:8] == WIT_KEY_CSR;
		end else if (wr_word && bus.offset == WIT_OFF_RST_WR) begin
			wr_rst_clr = bus.wdata == {WIT_KEY_RST_CLR, WIT_RST_CLR_DATA};
			wr_rst_bits = bus.wdata[15:8] == WIT_KEY_RST_BITS;
		end
		rdata_nxt = 8'h00;
		if (rd_byte && bus.offset == WIT_OFF_CSR) begin
			rdata_nxt = ctrl_status_reg;
		end else if (rd_byte && bus.offset == WIT_OFF_CNT) begin
			rdata_nxt = watchdog_counter_r;
		end else if (rd_byte && bus.offset == WIT_OFF_RST_RD) begin
			rdata_nxt = reset_ctrl_reg;
		end
		ack_nxt = bus.req;
	end

	// ****************************************
	// Counter, flags and pulse generators
	// ****************************************
	always_comb begin
		pre_nxt = pre_r + 13'h0001;
		tick = (pre_r & wit_div_mask(clock_divider_select_r)) ==
			wit_div_mask(clock_divider_select_r);
		tick = tick && count_enable_bit_r && !standby_in;
		wrap = tick && !wr_cnt && watchdog_counter_r == WIT_CNT_MAX;
		wd_wrap = wrap && mode_select_r;
		it_wrap = wrap && !mode_select_r;
		watchdog_counter_nxt = watchdog_counter_r;
		if (wr_cnt) begin
			watchdog_counter_nxt = bus.wdata[7:0];
		end else if (tick) begin
			watchdog_counter_nxt = watchdog_counter_r + 8'h01;
		end
		interval_overflow_flag_nxt = interval_overflow_flag_r;
		mode_select_nxt = mode_select_r;
		count_enable_bit_nxt = count_enable_bit_r;
		clock_divider_select_nxt = clock_divider_select_r;
		ovf_armed_nxt = ovf_armed_r;
		if (rd_byte && bus.offset == WIT_OFF_CSR && interval_overflow_flag_r) begin
			ovf_armed_nxt = 1'b1;
		end
		if (wr_csr) begin
			mode_select_nxt = bus.wdata[WIT_B_MODE];
			count_enable_bit_nxt = bus.wdata[WIT_B_TME];
			clock_divider_select_nxt = bus.wdata[2:0];
			ovf_armed_nxt = 1'b0;
			if (!bus.wdata[WIT_B_FLAG] && ovf_armed_r) begin
				interval_overflow_flag_nxt = 1'b0;
			end
		end
		if (it_wrap) begin
			interval_overflow_flag_nxt = 1'b1;
		end
		if (standby_in) begin
			interval_overflow_flag_nxt = 1'b0;
			mode_select_nxt = 1'b0;
			count_enable_bit_nxt = 1'b0;
		end
		if (wd_wrap) begin
			// Watchdog overflow always resets counter and control
			interval_overflow_flag_nxt = 1'b0;
			mode_select_nxt = 1'b0;
			count_enable_bit_nxt = 1'b0;
			clock_divider_select_nxt = 3'h0;
			watchdog_counter_nxt = WIT_CNT_RESET;
		end
		// Standby keeps the count but a counter write zeroes it; a disabled counter otherwise sits at zero
		if (!count_enable_bit_nxt && (wr_cnt || !standby_in)) begin
			watchdog_counter_nxt = WIT_CNT_RESET;
		end
		watchdog_overflow_flag_nxt = watchdog_overflow_flag_r;
		internal_reset_enable_nxt = internal_reset_enable_r;
		reset_type_select_nxt = reset_type_select_r;
		watchdog_overflow_flag_armed_nxt = watchdog_overflow_flag_armed_r;
		if (rd_byte && bus.offset == WIT_OFF_RST_RD && watchdog_overflow_flag_r) begin
			watchdog_overflow_flag_armed_nxt = 1'b1;
		end
		if (wr_rst_clr || wr_rst_bits) begin
			watchdog_overflow_flag_armed_nxt = 1'b0;
		end
		if (wr_rst_clr && watchdog_overflow_flag_armed_r) begin
			watchdog_overflow_flag_nxt = 1'b0;
		end
		if (wr_rst_bits) begin
			internal_reset_enable_nxt = bus.wdata[WIT_B_MODE];
			reset_type_select_nxt = bus.wdata[WIT_B_TME];
		end
		if (wd_wrap) begin
			watchdog_overflow_flag_nxt = 1'b1;
		end
		if (standby_in) begin
			watchdog_overflow_flag_nxt = 1'b0;
			internal_reset_enable_nxt = 1'b0;
			reset_type_select_nxt = 1'b0;
		end
		ovfo_cnt_nxt = (ovfo_cnt_r == 8'h00) ? 8'h00 : ovfo_cnt_r - 8'h01;
		if (wd_wrap) begin
			ovfo_cnt_nxt = WIT_OVF_OUT_CYC;
		end
		irst_cnt_nxt = (irst_cnt_r == 10'h000) ? 10'h000 : irst_cnt_r - 10'h001;
		irst_type_nxt = irst_type_r;
		if (wd_wrap && internal_reset_enable_r) begin
			irst_cnt_nxt = WIT_IRST_CYC;
			irst_type_nxt = reset_type_select_r;
		end
	end

	// Register everything; reset pin initialises all state
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pre_r <= '0;
			watchdog_counter_r <= WIT_CNT_RESET;
			interval_overflow_flag_r <= 1'b0;
			mode_select_r <= 1'b0;
			count_enable_bit_r <= 1'b0;
			clock_divider_select_r <= 3'h0;
			watchdog_overflow_flag_r <= 1'b0;
			internal_reset_enable_r <= 1'b0;
			reset_type_select_r <= 1'b0;
			ovf_armed_r <= 1'b0;
			watchdog_overflow_flag_armed_r <= 1'b0;
			ovfo_cnt_r <= 8'h00;
			irst_cnt_r <= 10'h000;
			irst_type_r <= 1'b0;
			bus.ack <= 1'b0;
			bus.rdata <= 8'h00;
			overflow_out_n_out <= 1'b1;
			interval_interrupt_out <= 1'b0;
			por_reset_out <= 1'b0;
			manual_reset_out <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			watchdog_counter_r <= watchdog_counter_nxt;
			interval_overflow_flag_r <= interval_overflow_flag_nxt;
			mode_select_r <= mode_select_nxt;
			count_enable_bit_r <= count_enable_bit_nxt;
			clock_divider_select_r <= clock_divider_select_nxt;
			watchdog_overflow_flag_r <= watchdog_overflow_flag_nxt;
			internal_reset_enable_r <= internal_reset_enable_nxt;
			reset_type_select_r <= reset_type_select_nxt;
			ovf_armed_r <= ovf_armed_nxt;
			watchdog_overflow_flag_armed_r <= watchdog_overflow_flag_armed_nxt;
			ovfo_cnt_r <= ovfo_cnt_nxt;
			irst_cnt_r <= irst_cnt_nxt;
			irst_type_r <= irst_type_nxt;
			bus.ack <= ack_nxt;
			bus.rdata <= rdata_nxt;
			overflow_out_n_out <= ovfo_cnt_nxt == 8'h00;
			interval_interrupt_out <= interval_overflow_flag_nxt;
			por_reset_out <= irst_cnt_nxt != 10'h000 && !irst_type_nxt;
			manual_reset_out <= irst_cnt_nxt != 10'h000 && irst_type_nxt;
		end
	end
endmodule : wit_device
`default_nettype wire

/* File: wit_chk.sv */
// Checker on the timer bus and device outputs
`timescale 1ns/10ps
`default_nettype none
module wit_chk import wit_pkg::*; (
	input wire logic sys_clk_in, // Clock
	input wire logic rst_n_in, // Reset, active low
	input wire logic req, // Bus request
	input wire logic wr, // Bus direction
	input wire logic [1:0] offset, // Bus offset
	input wire logic [7:0] rdata, // Read byte
	input wire logic ack, // Bus answer
	input wire logic overflow_out_n_out, // Overflow pin
	input wire logic interval_interrupt_out, // Interrupt
	input wire logic por_reset_out, // Power-on reset
	input wire logic manual_reset_out // Manual reset
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [7:0] lo_r, lo_nxt;
	logic [9:0] ir_r, ir_nxt;
	logic irst;
	assign irst = por_reset_out | manual_reset_out;
	// Count cycles of low overflow pin and of internal reset
	always_comb begin
		lo_nxt = overflow_out_n_out ? 8'h00 : lo_r + 8'h01;
		ir_nxt = irst ? ir_r + 10'h001 : 10'h000;
		if (!rst_n_in) begin
			lo_nxt = 8'h00;
			ir_nxt = 10'h000;
		end
	end
	// Register the counts
	always_ff @(posedge sys_clk_in) begin
		lo_r <= lo_nxt;
		ir_r <= ir_nxt;
	end
	AST_ACK_NEXT: assert property (req |=> ack) else $error("ack missing");
	AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("stray ack");
	AST_RD_OFF2: assert property (req && !wr && offset == WIT_OFF_RST_WR |=>
		rdata == 8'h00) else $error("read at write offset");
	AST_CSR_ONES: assert property (req && !wr && offset == WIT_OFF_CSR |=>
		rdata[4:3] == 2'h3) else $error("reserved bits");
	AST_RST_ONES: assert property (req && !wr && offset == WIT_OFF_RST_RD |=>
		rdata[4:0] == 5'h1F) else $error("reset reg low bits");
	AST_OVF_LEN: assert property ($rose(overflow_out_n_out) |-> lo_r == 8'h80)
		else $error("overflow pulse length");
	AST_IRST_LEN: assert property ($fell(irst) |-> ir_r == 10'h200)
		else $error("internal reset length");
	AST_RST_EXCL: assert property (!(por_reset_out && manual_reset_out))
		else $error("both reset kinds");
	AST_IRST_OVF: assert property ($rose(irst) |-> !overflow_out_n_out)
		else $error("reset without overflow");
	AST_WD_NO_INT: assert property (!overflow_out_n_out |-> !$rose(interval_interrupt_out))
		else $error("interrupt in watchdog mode");
	cover property ($rose(interval_interrupt_out));
	cover property ($fell(overflow_out_n_out));
	cover property ($rose(por_reset_out));
	cover property ($rose(manual_reset_out));
endmodule : wit_chk
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the timer host and device pair
`timescale 1ns/10ps
`default_nettype none
module tb import wit_pkg::*;;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, stby, ovf_n, interval_interrupt, por, man;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] lf;
	logic [2:0] outs;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	assign outs = {por | man, interval_interrupt, ovf_n};
	wit_bus_if bus();
	wit_host u_wit_host(.sys_clk_in(clk), .rst_n_in(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(bus));
	wit_device u_wit_device(.sys_clk_in(clk), .rst_n_in(rst_n), .standby_in(stby),
		.overflow_out_n_out(ovf_n), .interval_interrupt_out(interval_interrupt), .por_reset_out(por),
		.manual_reset_out(man), .bus(bus));
	wit_chk u_wit_chk(.sys_clk_in(clk), .rst_n_in(rst_n), .req(bus.req), .wr(bus.wr),
		.offset(bus.offset), .rdata(bus.rdata), .ack(bus.ack), .overflow_out_n_out(ovf_n),
		.interval_interrupt_out(interval_interrupt), .por_reset_out(por), .manual_reset_out(man));
	// Clock and cycle count
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Timer bus transfer through the host, polled to completion
	task automatic dev(input logic w, input logic [1:0] o, input logic [15:0] d,
		output logic [7:0] b);
		logic [31:0] r;
		logic e;
		apb(1'b1, WIT_APB_CMD, {13'h0000, w, o, d}, r, e);
		do apb(1'b0, WIT_APB_STAT, 32'h0, r, e); while (r[0] !== 1'b0);
		b = r[15:8];
	endtask : dev
	task automatic waitsig(input int k, input logic lv, input int lim);
		int n;
		n = 0;
		while (outs[k] !== lv && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) chk("wait", 32'h0, 32'h1);
	endtask : waitsig
	task automatic summarize;
		$display("Compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	// Watchdog against a hang
	initial begin
		#4000000;
		n_mismatch++;
		summarize();
	end
	// Main sequence
	initial begin
		logic [7:0] b, rb;
		logic [31:0] r;
		logic e;
		int t0, d, np, el;
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; stby = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; lf = 16'h2DAC;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		dev(1'b0, WIT_OFF_CSR, 16'h0, b); chk("csr", 32'(b), 32'h18);
		dev(1'b0, WIT_OFF_CNT, 16'h0, b); chk("cnt", 32'(b), 32'h00);
		dev(1'b0, WIT_OFF_RST_RD, 16'h0, b); chk("rst", 32'(b), 32'h1F);
		dev(1'b1, WIT_OFF_CSR, 16'h1234, b);
		apb(1'b0, WIT_APB_CMD, 32'h0, r, e);
		chk("cmd rd", r, 32'h00041234);
		dev(1'b0, WIT_OFF_CSR, 16'h0, b); chk("csr key", 32'(b), 32'h18);
		dev(1'b1, WIT_OFF_CSR, 16'h5A10, b);
		dev(1'b0, WIT_OFF_CNT, 16'h0, b); chk("cnt off", 32'(b), 32'h00);
		dev(1'b0, WIT_OFF_RST_WR, 16'h0, b); chk("rd off2", 32'(b), 32'h00);
		apb(1'b0, 8'h40, 32'h0, r, e); chk("pslverr", 32'(e), 32'h1);
		$display("reset and refusal test done");
		dev(1'b1, WIT_OFF_CSR, 16'hA53F, b);
		repeat (4) begin
			lf = lfsr(lf);
			dev(1'b1, WIT_OFF_RST_WR, {WIT_KEY_RST_BITS, lf[7:0]}, b);
			dev(1'b0, WIT_OFF_RST_RD, 16'h0, b);
			chk("rst bits", 32'(b), 32'({lf[6:5], 5'h1F}));
			dev(1'b1, WIT_OFF_CSR, {WIT_KEY_CNT, lf[15:8]}, b);
			dev(1'b0, WIT_OFF_CNT, 16'h0, b); chk("cnt wr", 32'((b - lf[15:8]) < 8'h02), 1);
		end
		dev(1'b1, WIT_OFF_CSR, 16'hA518, b);
		dev(1'b0, WIT_OFF_CSR, 16'h0, b);
		dev(1'b1, WIT_OFF_CSR, 16'hA518, b);
		$display("random write test done");
		for (int c = 0; c < 8; c++) begin
			d = (c == 0) ? 2 : (c < 6) ? (32 << c) : (c == 6) ? 4096 : 8192;
			np = (d >= 1024) ? 2 : 16;
			dev(1'b1, WIT_OFF_CSR, {WIT_KEY_CSR, 5'b00111, 3'(c)}, b);
			dev(1'b1, WIT_OFF_CSR, {WIT_KEY_CNT, 8'(256 - np)}, b);
			t0 = cyc;
			waitsig(1, 1'b1, 30000);
			el = cyc - t0;
			chk("period", 32'(el >= (np - 1) * d - 12 && el <= np * d + 12), 1);
			dev(1'b0, WIT_OFF_CSR, 16'h0, b);
			chk("flag", 32'(b), 32'({5'b10111, 3'(c)}));
			chk("ovf pin", 32'(ovf_n), 1);
			dev(1'b1, WIT_OFF_CSR, {WIT_KEY_CSR, 5'b10111, 3'(c)}, b);
			chk("flag one", 32'(interval_interrupt), 1);
			dev(1'b0, WIT_OFF_CSR, 16'h0, b);
			dev(1'b1, WIT_OFF_CSR, {WIT_KEY_CSR, 5'b00011, 3'(c)}, b);
			chk("irq clr", 32'(interval_interrupt), 0);
		end
		$display("interval test done");
		for (int k = 0; k < 3; k++) begin
			rb = (k == 0) ? 8'h40 : (k == 1) ? 8'h60 : 8'h00;
			dev(1'b1, WIT_OFF_RST_WR, {WIT_KEY_RST_BITS, rb}, b);
			dev(1'b1, WIT_OFF_CSR, 16'hA578, b);
			dev(1'b1, WIT_OFF_CSR, 16'h5AF0, b);
			waitsig(0, 1'b0, 1000);
			repeat (2) @(posedge clk);
			chk("por", 32'(por), 32'(k == 0));
			chk("manual", 32'(man), 32'(k == 1));
			chk("irq", 32'(interval_interrupt), 0);
			dev(1'b0, WIT_OFF_CSR, 16'h0, b); chk("csr wd", 32'(b), 32'h18);
			dev(1'b1, WIT_OFF_RST_WR, 16'hA500, b);
			dev(1'b0, WIT_OFF_RST_RD, 16'h0, b);
			chk("wflag", 32'(b), 32'({rb[6:5], 5'h1F} | 8'h80));
			dev(1'b1, WIT_OFF_RST_WR, 16'hA500, b);
			dev(1'b0, WIT_OFF_RST_RD, 16'h0, b);
			chk("wclr", 32'(b), 32'({rb[6:5], 5'h1F}));
			waitsig(2, 1'b0, 1000);
			waitsig(0, 1'b1, 1000);
		end
		$display("watchdog test done");
		dev(1'b1, WIT_OFF_RST_WR, 16'h5A60, b);
		dev(1'b1, WIT_OFF_CSR, 16'hA53B, b);
		dev(1'b1, WIT_OFF_CSR, 16'h5A40, b);
		stby <= 1'b1;
		dev(1'b0, WIT_OFF_CNT, 16'h0, rb);
		chk("cnt stby", 32'((rb - 8'h40) < 8'h02), 1);
		dev(1'b0, WIT_OFF_CNT, 16'h0, b); chk("cnt hold", 32'(b), 32'(rb));
		dev(1'b0, WIT_OFF_CSR, 16'h0, b); chk("csr stby", 32'(b), 32'h1B);
		dev(1'b0, WIT_OFF_RST_RD, 16'h0, b); chk("rst stby", 32'(b), 32'h1F);
		stby <= 1'b0;
		dev(1'b0, WIT_OFF_CNT, 16'h0, b); chk("cnt exit", 32'(b), 32'h00);
		dev(1'b1, WIT_OFF_RST_WR, 16'h5A60, b);
		dev(1'b0, WIT_OFF_RST_RD, 16'h0, b); chk("rst set", 32'(b), 32'h7F);
		// Pin reset in mid run must bring the reset register back
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		dev(1'b0, WIT_OFF_RST_RD, 16'h0, b); chk("rst pin", 32'(b), 32'h1F);
		dev(1'b0, WIT_OFF_CSR, 16'h0, b); chk("csr pin", 32'(b), 32'h18);
		$display("standby and pin reset test done");
		summarize();
	end
endmodule : tb
`default_nettype wire
